//--- logic/acc_pkg.sv
package acc_pkg;
    // register byte addresses (printed offsets not all multiples of four: index * 4)
    localparam logic [7:0] ACC_IDX_CTRL_ONE = 8'h0E;
    localparam logic [7:0] ACC_IDX_CTRL_TWO = 8'h0F;
    localparam logic [7:0] ACC_IDX_RESULT = 8'h20;
    localparam logic [7:0] ACC_IDX_STATUS = 8'h21;
    localparam logic [11:0] ACC_ADDR_CTRL_ONE = {2'h0, ACC_IDX_CTRL_ONE, 2'h0};
    localparam logic [11:0] ACC_ADDR_CTRL_TWO = {2'h0, ACC_IDX_CTRL_TWO, 2'h0};
    localparam logic [11:0] ACC_ADDR_RESULT = {2'h0, ACC_IDX_RESULT, 2'h0};
    localparam logic [11:0] ACC_ADDR_STATUS = {2'h0, ACC_IDX_STATUS, 2'h0};
    // control one fields
    localparam int ACC_C1_START_BIT = 7;
    localparam int ACC_C1_AIN_DIS_BIT = 4;
    localparam logic [7:0] ACC_C1_RESET = 8'h1F;
    localparam logic [7:0] ACC_C1_FIXED_MASK = 8'h60;
    localparam logic [7:0] ACC_C1_FIXED_VAL = 8'h20;
    // control two fields
    localparam int ACC_C2_LADDER_BIT = 5;
    localparam logic [7:0] ACC_C2_RESET = 8'h10;
    localparam logic [7:0] ACC_C2_FIXED_MASK = 8'h11;
    localparam logic [7:0] ACC_C2_FIXED_VAL = 8'h10;
    // status fields
    localparam int ACC_ST_DONE_BIT = 5;
    localparam int ACC_ST_BUSY_BIT = 4;
    localparam logic [7:0] ACC_RESULT_RESET = 8'h00;
    // conversion time codes and cycle counts
    localparam logic [2:0] ACC_CT_39 = 3'h0;
    localparam logic [2:0] ACC_CT_78 = 3'h2;
    localparam logic [2:0] ACC_CT_156 = 3'h3;
    localparam logic [2:0] ACC_CT_312 = 3'h4;
    localparam logic [2:0] ACC_CT_624 = 3'h5;
    localparam logic [2:0] ACC_CT_1248 = 3'h6;
    localparam logic [10:0] ACC_CYC_39 = 11'd39;
    localparam logic [10:0] ACC_CYC_78 = 11'd78;
    localparam logic [10:0] ACC_CYC_156 = 11'd156;
    localparam logic [10:0] ACC_CYC_312 = 11'd312;
    localparam logic [10:0] ACC_CYC_624 = 11'd624;
    localparam logic [10:0] ACC_CYC_1248 = 11'd1248;
    localparam int ACC_STEPS = 9;
    localparam logic [3:0] ACC_CH_LAST = 4'h7;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_SAMPLE = 3'b010,
        ACC_DECIDE = 3'b100
    } acc_state_t;
endpackage : acc_pkg

//--- logic/acc_step_timer.sv
`timescale 1ns/1ps
// divides the selected conversion time into nine step ticks
module acc_step_timer
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic run,
    input wire logic [2:0] timeSel,
    output logic stepTick
);
    import acc_pkg::*;

    typedef struct packed {
        logic [10:0] cnt;
        logic [3:0] step;
        logic tick;
    } acc_tmr_t;

    acc_tmr_t s_r;
    acc_tmr_t s_nxt;
    logic [10:0] total;
    logic [10:0] stepLen;
    logic [10:0] lastLen;

    always_comb begin
        case (timeSel)
            ACC_CT_78: total = ACC_CYC_78;
            ACC_CT_156: total = ACC_CYC_156;
            ACC_CT_312: total = ACC_CYC_312;
            ACC_CT_624: total = ACC_CYC_624;
            ACC_CT_1248: total = ACC_CYC_1248;
            default: total = ACC_CYC_39;
        endcase
    end

    // remainder goes to the last step so the whole adds up exactly
    assign stepLen = 11'(total / 11'(ACC_STEPS));
    assign lastLen = 11'(total - 11'(stepLen * 11'(ACC_STEPS - 1)));

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = 11'h000;
            s_nxt.step = 4'h0;
        end else if (s_r.cnt + 11'h001 >= ((s_r.step == 4'(ACC_STEPS - 1)) ? lastLen : stepLen)) begin
            s_nxt.cnt = 11'h000;
            s_nxt.step = 4'(s_r.step + 4'h1);
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = 11'(s_r.cnt + 11'h001);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    assign stepTick = s_r.tick;
endmodule : acc_step_timer

//--- logic/acc_conv_ctrl.sv
`timescale 1ns/1ps
//
// Functional notes
// - writing start bit begins conversion of the selected channel
// - start bit clears itself once conversion begins; reads zero
// - conversion ends after the selected conversion time from the start request
// - completion stores result, sets done flag, pulses interrupt, same cycle
// - a read of the result register clears the done flag, except in the cycle a conversion completes
// - busy set at start, cleared at finish
// - busy cleared on entry to stop or slow mode
// - done flag at bit 5, read-only
// - busy flag at bit 4, read-only
// - other status bits are unstable; here read as zero
// - restart clears done flag; result kept until the new one completes
// - stop or slow entry aborts and resets both control registers
// - after low-power return the block stays idle until a new start
// - low-power entry disconnects the reference ladder
// - channel codes 0 to 7 select inputs; others reserved, reset value
// - time codes select 39,78,156,312,624,1248 cycles; 001, 111 reserved
// - ladder bit 0 connects only during conversion, 1 always
//
module acc_conv_ctrl
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lowPowerEntry,
    input wire logic compHigh,
    output logic [3:0] inputChannelSel,
    output logic analogInputDisable,
    output logic sampleHold,
    output logic [7:0] dacCode,
    output logic ladderOn,
    output logic convDoneIrq
);
    import acc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic compMeta;
        logic compSync;
        logic lpMeta;
        logic lpSync;
        acc_state_t fsm;
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic [7:0] result;
        logic [7:0] trial;
        logic [2:0] bitIdx;
        logic done;
        logic busy;
        logic irq;
        logic sample;
        logic ladder;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } acc_ctl_t;

    acc_ctl_t s_r;
    acc_ctl_t s_nxt;
    logic stepTick;
    logic run;
    logic access;
    logic xfer;
    logic wrOne;
    logic wrTwo;
    logic startReq;
    logic mapped;

    assign run = (s_r.fsm != ACC_IDLE);
    assign access = psel && penable && !s_r.ready;
    // side effects land on the edge that sees pready high, not on the wait edge
    assign xfer = psel && penable && s_r.ready;
    assign mapped = (paddr == ACC_ADDR_CTRL_ONE) || (paddr == ACC_ADDR_CTRL_TWO) ||
                    (paddr == ACC_ADDR_RESULT) || (paddr == ACC_ADDR_STATUS);
    // writes are locked out during low-power mode
    assign wrOne = xfer && pwrite && (paddr == ACC_ADDR_CTRL_ONE) && !s_r.lpSync;
    assign wrTwo = xfer && pwrite && (paddr == ACC_ADDR_CTRL_TWO) && !s_r.lpSync;
    assign startReq = wrOne && pwdata[ACC_C1_START_BIT];

    acc_step_timer u_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .run(run),
        .timeSel(s_r.ctrlTwo[3:1]),
        .stepTick(stepTick)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.compMeta = compHigh;
        s_nxt.compSync = s_r.compMeta;
        s_nxt.lpMeta = lowPowerEntry;
        s_nxt.lpSync = s_r.lpMeta;
        s_nxt.irq = 1'b0;
        s_nxt.ready = access;
        s_nxt.err = access && !mapped;
        s_nxt.rdata = 32'h0000_0000;

        // bus writes; fixed bits forced to their required values
        if (wrOne) begin
            s_nxt.ctrlOne = (pwdata[7:0] & ~ACC_C1_FIXED_MASK) | ACC_C1_FIXED_VAL;
            s_nxt.ctrlOne[ACC_C1_START_BIT] = 1'b0;
        end
        if (wrTwo) begin
            s_nxt.ctrlTwo = (pwdata[7:0] & ~ACC_C2_FIXED_MASK) | ACC_C2_FIXED_VAL;
        end

        // bus reads
        if (access && !pwrite) begin
            case (paddr)
                ACC_ADDR_CTRL_ONE: s_nxt.rdata = {24'h000000, s_r.ctrlOne};
                ACC_ADDR_CTRL_TWO: s_nxt.rdata = {24'h000000, 2'b00, s_r.ctrlTwo[5:0]};
                ACC_ADDR_RESULT: s_nxt.rdata = {24'h000000, s_r.result};
                ACC_ADDR_STATUS: begin
                    s_nxt.rdata[ACC_ST_DONE_BIT] = s_r.done;
                    s_nxt.rdata[ACC_ST_BUSY_BIT] = s_r.busy;
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (xfer && !pwrite && (paddr == ACC_ADDR_RESULT)) begin
            s_nxt.done = 1'b0;
        end

        // sequencer
        case (s_r.fsm)
            ACC_IDLE: begin
                if (startReq) begin
                    s_nxt.fsm = ACC_SAMPLE;
                    s_nxt.busy = 1'b1;
                    s_nxt.done = 1'b0;
                    s_nxt.sample = 1'b1;
                    s_nxt.trial = 8'h80;
                    s_nxt.bitIdx = 3'h7;
                end
            end
            ACC_SAMPLE: begin
                if (stepTick) begin
                    s_nxt.fsm = ACC_DECIDE;
                    s_nxt.sample = 1'b0;
                end
            end
            ACC_DECIDE: begin
                if (stepTick) begin
                    // keep the trial bit only while the input is above the ladder
                    s_nxt.trial[s_r.bitIdx] = s_r.compSync;
                    if (s_r.bitIdx == 3'h0) begin
                        s_nxt.fsm = ACC_IDLE;
                        s_nxt.result = {s_r.trial[7:1], s_r.compSync};
                        s_nxt.done = 1'b1;
                        s_nxt.irq = 1'b1;
                        s_nxt.busy = 1'b0;
                    end else begin
                        s_nxt.bitIdx = 3'(s_r.bitIdx - 3'h1);
                        s_nxt.trial[3'(s_r.bitIdx - 3'h1)] = 1'b1;
                    end
                end
            end
            default: s_nxt.fsm = ACC_IDLE;
        endcase

        // low-power entry overrides everything, including a pending start
        if (s_r.lpSync) begin
            s_nxt.fsm = ACC_IDLE;
            s_nxt.ctrlOne = ACC_C1_RESET;
            s_nxt.ctrlTwo = ACC_C2_RESET;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.irq = 1'b0;
            s_nxt.sample = 1'b0;
            s_nxt.result = ACC_RESULT_RESET;
        end

        s_nxt.ladder = !s_r.lpSync && (s_nxt.ctrlTwo[ACC_C2_LADDER_BIT] || (s_nxt.fsm != ACC_IDLE));
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_r <= '{fsm: ACC_IDLE, ctrlOne: ACC_C1_RESET, ctrlTwo: ACC_C2_RESET,
                     result: ACC_RESULT_RESET, rdata: 32'h0000_0000, trial: 8'h00, bitIdx: 3'h0, default: 1'b0};
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = s_r.rdata;
    assign pready = s_r.ready;
    assign pslverr = s_r.err;
    assign inputChannelSel = s_r.ctrlOne[3:0];
    assign analogInputDisable = s_r.ctrlOne[ACC_C1_AIN_DIS_BIT];
    assign sampleHold = s_r.sample;
    assign dacCode = s_r.trial;
    assign ladderOn = s_r.ladder;
    assign convDoneIrq = s_r.irq;

    // ****************************************
    // checks
    // ****************************************
    property p_irq_pulse;
        @(posedge ref_clk) disable iff (!rstn)
        convDoneIrq |=> !convDoneIrq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

    property p_done_with_irq;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(convDoneIrq) |-> s_r.done && !s_r.busy;
    endproperty
    a_done_with_irq: assert property (p_done_with_irq) else $error("done not set with irq");

    property p_start_busy;
        @(posedge ref_clk) disable iff (!rstn)
        (clkEn && startReq && s_r.fsm == ACC_IDLE && !s_r.lpSync) |=> s_r.busy && !s_r.done;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

    property p_start_clear;
        @(posedge ref_clk) disable iff (!rstn)
        !s_r.ctrlOne[ACC_C1_START_BIT];
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit reads one");

    property p_result_read;
        @(posedge ref_clk) disable iff (!rstn)
        (clkEn && xfer && !pwrite && paddr == ACC_ADDR_RESULT && !convDoneIrq && s_r.fsm != ACC_DECIDE)
            |=> !s_r.done;
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read kept done");

    property p_lp_abort;
        @(posedge ref_clk) disable iff (!rstn)
        (clkEn && s_r.lpSync) |=> s_r.fsm == ACC_IDLE && !s_r.busy && !ladderOn && s_r.ctrlTwo == ACC_C2_RESET;
    endproperty
    a_lp_abort: assert property (p_lp_abort) else $error("low power did not abort");

    property p_result_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (!convDoneIrq && !s_r.lpSync) |=> $stable(s_r.result) || convDoneIrq || $past(s_r.lpSync);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed early");

    property p_busy_ladder;
        @(posedge ref_clk) disable iff (!rstn)
        s_r.busy && !s_r.lpSync |-> ##1 (ladderOn || s_r.lpSync || !s_r.busy);
    endproperty
    a_busy_ladder: assert property (p_busy_ladder) else $error("ladder off in conversion");
endmodule : acc_conv_ctrl

//--- dv/acc_comp_model.sv
`timescale 1ns/1ps
// ****************
// comparator and ladder model
// ****************
module acc_comp_model (
    input wire logic ref_clk,
    input wire logic sampleHold,
    input wire logic ladderOn,
    input wire logic [3:0] inputChannelSel,
    input wire logic [7:0] dacCode,
    input wire logic [63:0] levels,
    output logic compHigh
);
    logic [7:0] held;
    logic junk;
    initial begin
        held = 8'h00;
        junk = 1'b0;
    end
    // reserved channel codes select nothing, so the old sample stays
    always @(posedge ref_clk) begin
        junk <= ~junk;
        if (sampleHold && !inputChannelSel[3]) begin
            held <= levels[{inputChannelSel[2:0], 3'h0} +: 8];
        end
    end
    // ladder off means no valid compare: toggle so a stale level never looks right
    assign compHigh = ladderOn ? (held >= dacCode) : junk;
endmodule : acc_comp_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import acc_pkg::*;
    logic ref_clk, rstn, psel, penable, pwrite, lowPowerEntry, compHigh;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, analogInputDisable, sampleHold, ladderOn, convDoneIrq;
    logic [3:0] inputChannelSel;
    logic [7:0] dacCode;
    logic [63:0] levels;
    int err_count, checks, n;
    logic [2:0] codes [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1};
    int cyc [7] = '{39, 78, 156, 312, 624, 1248, 39};

    acc_conv_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lowPowerEntry(lowPowerEntry), .compHigh(compHigh),
        .inputChannelSel(inputChannelSel), .analogInputDisable(analogInputDisable),
        .sampleHold(sampleHold), .dacCode(dacCode), .ladderOn(ladderOn), .convDoneIrq(convDoneIrq));
    acc_comp_model u_model (.ref_clk(ref_clk), .sampleHold(sampleHold), .ladderOn(ladderOn),
        .inputChannelSel(inputChannelSel), .dacCode(dacCode), .levels(levels), .compHigh(compHigh));

    // ****************
    // clock, tasks
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    // configure first, then start on channel 3
    task automatic start(input logic [2:0] code);
        apb(1'b1, ACC_ADDR_CTRL_TWO, {24'h0, 4'h1, code, 1'b0});
        apb(1'b1, ACC_ADDR_CTRL_ONE, 32'h0000_00A3);
    endtask : start

    // slack above the count covers the start write landing and the registered step tick
    task automatic waitDone(input int e);
        n = 0;
        while (convDoneIrq !== 1'b1 && n < 1400) begin // no other bus traffic
            @(posedge ref_clk);
            n++;
        end
        chk("conv time", 32'h1, 32'(n >= e - 1 && n <= e + 4));
        @(posedge ref_clk);
        chk("irq pulse", 32'h0, {31'h0, convDoneIrq});
    endtask : waitDone

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        results();
    end

    // ****************
    // tests
    // ****************
    initial begin
        {rstn, psel, penable, pwrite, lowPowerEntry} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        levels = 64'h1122_3344_A566_7708;
        err_count = 0;
        checks = 0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rdc("ctrl one rst", ACC_ADDR_CTRL_ONE, 32'h1F);
        rdc("ctrl two rst", ACC_ADDR_CTRL_TWO, 32'h10);
        rdc("result rst", ACC_ADDR_RESULT, 32'h00);
        rdc("status rst", ACC_ADDR_STATUS, 32'h00);
        chk("channel rst", 32'hF, {28'h0, inputChannelSel});
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, ACC_ADDR_CTRL_ONE, 32'h23);
        @(posedge ref_clk);
        chk("channel", 32'h3, {28'h0, inputChannelSel});
        chk("input dis", 32'h0, {31'h0, analogInputDisable});
        for (int i = 0; i < 7; i++) begin
            levels[31:24] <= 8'(19 * (i + 5));
            start(codes[i]);
            waitDone(cyc[i]);
            rdc("status done", ACC_ADDR_STATUS, 32'h20);
            rdc("result", ACC_ADDR_RESULT, {24'h0, 8'(19 * (i + 5))});
            rdc("status clr", ACC_ADDR_STATUS, 32'h00);
        end
        // restart before the result is read
        levels[31:24] <= 8'hC4;
        start(3'h0);
        waitDone(39);
        levels[31:24] <= 8'h3B;
        start(3'h6);
        @(posedge ref_clk);
        chk("ladder conv", 32'h1, {31'h0, ladderOn});
        rdc("status busy", ACC_ADDR_STATUS, 32'h10);
        rdc("ctrl one auto", ACC_ADDR_CTRL_ONE, 32'h23);
        rdc("result kept", ACC_ADDR_RESULT, 32'hC4);
        waitDone(1248 - 12);
        rdc("result new", ACC_ADDR_RESULT, 32'h3B);
        apb(1'b1, ACC_ADDR_CTRL_TWO, 32'h30);
        repeat (2) @(posedge ref_clk);
        chk("ladder always", 32'h1, {31'h0, ladderOn});
        apb(1'b1, ACC_ADDR_CTRL_TWO, 32'h10);
        repeat (2) @(posedge ref_clk);
        chk("ladder idle", 32'h0, {31'h0, ladderOn});
        // forced low-power entry in mid conversion
        start(3'h6);
        rdc("result pre lp", ACC_ADDR_RESULT, 32'h3B);
        repeat (20) @(posedge ref_clk);
        lowPowerEntry <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("ladder lp", 32'h0, {31'h0, ladderOn});
        rdc("status lp", ACC_ADDR_STATUS, 32'h00);
        rdc("ctrl one lp", ACC_ADDR_CTRL_ONE, 32'h1F);
        rdc("ctrl two lp", ACC_ADDR_CTRL_TWO, 32'h10);
        rdc("result lp", ACC_ADDR_RESULT, 32'h00);
        apb(1'b1, ACC_ADDR_CTRL_ONE, 32'hA3);
        rdc("ctrl one lock", ACC_ADDR_CTRL_ONE, 32'h1F);
        lowPowerEntry <= 1'b0;
        n = 0;
        repeat (1400) begin
            @(posedge ref_clk);
            if (convDoneIrq !== 1'b0) n++;
        end
        chk("no resume", 32'h0, 32'(n));
        rdc("status idle", ACC_ADDR_STATUS, 32'h00);
        results();
    end
endmodule : tb_top
